//--- hw/tsf_sample_fifo.sv
`default_nettype none
module tsf_sample_fifo (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sample_valid,
    input wire logic [tsf_pkg::SAMPLE_W-1:0] sample_data,
    input wire logic burst_start,
    input wire logic [tsf_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [tsf_pkg::BYTE_W-1:0] reg_wdata,
    input wire logic reg_rd,
    output logic [tsf_pkg::BYTE_W-1:0] reg_rdata,
    output logic addr_hold,
    input wire logic status_read,
    input wire logic af_irq_enable,
    input wire logic [tsf_pkg::FUNC_W-1:0] event_pin_function,
    output logic almost_full_flag,
    output logic sample_ready_clear,
    output logic event_pin_irq
);
    import tsf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [SAMPLE_W-1:0] mem [DEPTH];
    logic [IDX_W-1:0] write_index_q;
    logic [IDX_W-1:0] read_index_q;
    logic [IDX_W-1:0] read_index_d;
    logic [IDX_W-1:0] lost_word_counter_q;
    logic [IDX_W-1:0] lost_word_counter_d;
    logic [CNT_W-1:0] avail_q;
    logic [CNT_W-1:0] avail_d;
    logic [IDX_W-1:0] thresh_q;
    logic overwrite_when_full_q;
    logic af_type_q;
    logic clear_flags_on_pop_q;
    logic byte_phase_q;
    logic af_cond_q;
    logic af_cond_d;
    logic almost_full_q;
    logic [BYTE_W-1:0] rdata_q;
    logic [BYTE_W-1:0] rdata_d;

    ////////////////////////////////////////////////////////////////////////
    // decode
    logic port_read;
    logic pop;
    logic full;
    logic push_normal;
    logic push_full;
    logic flush;
    logic [SAMPLE_W-1:0] head_word;
    logic [CNT_W-1:0] af_level;
    logic idx_write;
    logic thresh_write;
    logic behav_write;
    logic store;
    logic [BYTE_W-1:0] port_byte;

    assign port_read = reg_rd && (reg_addr == OFS_READ_PORT);
    assign idx_write = reg_wr && (reg_addr == OFS_READ_INDEX);
    assign thresh_write = reg_wr && (reg_addr == OFS_THRESH_CFG);
    assign behav_write = reg_wr && (reg_addr == OFS_BEHAV_CFG);

    assign pop = port_read && byte_phase_q;
    assign full = (avail_q == AVAIL_FULL);
    // a pop in the same cycle frees a slot, so the push is normal
    assign push_normal = sample_valid && (!full || pop);
    assign push_full = sample_valid && full && !pop;
    assign store = !flush && (push_normal || (push_full && overwrite_when_full_q));
    assign flush = behav_write && reg_wdata[BIT_FLUSH];
    assign head_word = mem[read_index_q];
    assign af_level = AVAIL_FULL - {1'b0, thresh_q};
    assign addr_hold = (reg_addr == OFS_READ_PORT);

    ////////////////////////////////////////////////////////////////////////
    // storage
    // storage has no reset: the indices and the available count say what is valid
    // overwrite stores sample
    always_ff @(posedge ref_clk) begin
        if (store) begin
            mem[write_index_q] <= sample_data;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            write_index_q <= IDX_RESET;
        end else if (flush) begin
            write_index_q <= IDX_RESET;
        end else if (store) begin
            write_index_q <= write_index_q + 5'h01;
        end
    end

    always_comb begin
        read_index_d = read_index_q;
        if (flush) begin
            read_index_d = IDX_RESET;
        end else if (idx_write) begin
            read_index_d = reg_wdata[IDX_W-1:0];
        end else if (pop || (push_full && overwrite_when_full_q)) begin
            read_index_d = read_index_q + 5'h01;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            read_index_q <= IDX_RESET;
        end else begin
            read_index_q <= read_index_d;
        end
    end

    // lost counter
    // overwrite pushes count as lost words too
    always_comb begin
        lost_word_counter_d = lost_word_counter_q;
        if (flush) begin
            lost_word_counter_d = LOST_RESET;
        end else if (pop) begin
            lost_word_counter_d = LOST_RESET;
        end else if (push_full && (lost_word_counter_q != LOST_MAX)) begin
            lost_word_counter_d = lost_word_counter_q + 5'h01;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lost_word_counter_q <= LOST_RESET;
        end else begin
            lost_word_counter_q <= lost_word_counter_d;
        end
    end

    always_comb begin
        avail_d = avail_q;
        if (push_normal && !pop) begin
            avail_d = avail_q + 6'h01;
        // a pop on an empty queue leaves the count at zero
        end else if (pop && !push_normal && (avail_q != AVAIL_RESET)) begin
            avail_d = avail_q - 6'h01;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avail_q <= AVAIL_RESET;
        end else if (flush) begin
            avail_q <= AVAIL_RESET;
        end else begin
            avail_q <= avail_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            thresh_q <= THRESH_RESET;
        end else if (thresh_write) begin
            thresh_q <= reg_wdata[IDX_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            overwrite_when_full_q <= 1'b0;
            af_type_q <= 1'b0;
            clear_flags_on_pop_q <= 1'b0;
        end else if (behav_write) begin
            overwrite_when_full_q <= reg_wdata[BIT_OVERWRITE];
            af_type_q <= reg_wdata[BIT_AF_TYPE];
            clear_flags_on_pop_q <= reg_wdata[BIT_CLR_ON_POP];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // almost-full flag
    // judged on the next count so the flag lands with the push
    assign af_cond_d = flush ? 1'b0 : (avail_d >= af_level);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            af_cond_q <= 1'b0;
        end else begin
            af_cond_q <= af_cond_d;
        end
    end

    logic af_set;
    logic af_clear;
    logic af_rise;
    logic af_renew;
    assign af_rise = af_cond_d && !af_cond_q;
    assign af_renew = af_cond_d && sample_valid;
    assign af_set = af_type_q ? af_rise : (af_rise || af_renew);
    // status read clears, data read too when clear_flags_on_pop_q is set
    assign af_clear = status_read || (port_read && clear_flags_on_pop_q);

    // set wins over clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            almost_full_q <= 1'b0;
        end else if (af_set) begin
            almost_full_q <= 1'b1;
        end else if (af_clear) begin
            almost_full_q <= 1'b0;
        end
    end

    assign almost_full_flag = almost_full_q;
    assign sample_ready_clear = port_read && clear_flags_on_pop_q;
    assign event_pin_irq = almost_full_q && af_irq_enable && (event_pin_function == FUNC_AF_IRQ);

    ////////////////////////////////////////////////////////////////////////
    // register read port
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            byte_phase_q <= 1'b0;
        end else if (burst_start || flush) begin
            byte_phase_q <= 1'b0;
        // an index rewrite restarts at the upper byte
        end else if (idx_write) begin
            byte_phase_q <= 1'b0;
        end else if (port_read) begin
            byte_phase_q <= !byte_phase_q;
        end
    end

    assign port_byte = byte_phase_q ? head_word[7:0] : head_word[15:8];

    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_WRITE_INDEX: rdata_d = {3'h0, write_index_q};
                OFS_READ_INDEX: rdata_d = {3'h0, read_index_q};
                OFS_LOST_COUNT: rdata_d = {3'h0, lost_word_counter_q};
                OFS_AVAIL_COUNT: rdata_d = {2'h0, avail_q};
                OFS_READ_PORT: rdata_d = port_byte;
                OFS_THRESH_CFG: rdata_d = {3'h0, thresh_q};
                OFS_BEHAV_CFG: rdata_d = {4'h0, clear_flags_on_pop_q, af_type_q, overwrite_when_full_q, 1'b0};
                // unmapped offsets read as zero
                default: rdata_d = RDATA_RESET;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= RDATA_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
endmodule : tsf_sample_fifo
`default_nettype wire

//--- shared/tsf_pkg.sv
`default_nettype none
package tsf_pkg;
    localparam int DEPTH = 32;
    localparam int IDX_W = 5;
    localparam int CNT_W = 6;
    localparam int SAMPLE_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 8;
    localparam int FUNC_W = 2;

    // register offsets on the byte-wide register port
    localparam logic [7:0] OFS_WRITE_INDEX = 8'h04;
    localparam logic [7:0] OFS_READ_INDEX = 8'h05;
    localparam logic [7:0] OFS_LOST_COUNT = 8'h06;
    localparam logic [7:0] OFS_AVAIL_COUNT = 8'h07;
    localparam logic [7:0] OFS_READ_PORT = 8'h08;
    localparam logic [7:0] OFS_THRESH_CFG = 8'h09;
    localparam logic [7:0] OFS_BEHAV_CFG = 8'h0A;

    // field positions in the behaviour configuration register
    localparam int BIT_FLUSH = 4;
    localparam int BIT_CLR_ON_POP = 3;
    localparam int BIT_AF_TYPE = 2;
    localparam int BIT_OVERWRITE = 1;

    // values after reset and limits
    localparam logic [4:0] IDX_RESET = 5'h00;
    localparam logic [4:0] LOST_MAX = 5'h1F;
    localparam logic [4:0] LOST_RESET = 5'h00;
    localparam logic [5:0] AVAIL_RESET = 6'h00;
    localparam logic [5:0] AVAIL_FULL = 6'h20;
    localparam logic [4:0] THRESH_RESET = 5'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic [1:0] FUNC_AF_IRQ = 2'h3;
endpackage : tsf_pkg
`default_nettype wire

//--- tb/tsf_sample_fifo_monitor.sv
`default_nettype none
module tsf_sample_fifo_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sample_valid,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic addr_hold,
    input wire logic status_read,
    input wire logic af_irq_enable,
    input wire logic [1:0] event_pin_function,
    input wire logic almost_full_flag,
    input wire logic sample_ready_clear,
    input wire logic event_pin_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    import tsf_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // anything that may set the flag
    logic busy;
    assign busy = sample_valid || reg_wr;
    a_addr_hold: assert property (addr_hold == (reg_addr == OFS_READ_PORT))
        else $error("address hold mismatch");
    a_irq_gate: assert property (event_pin_irq == (almost_full_flag && af_irq_enable
        && event_pin_function == FUNC_AF_IRQ)) else $error("event pin mismatch");
    a_pop_source: assert property (sample_ready_clear |-> reg_rd && reg_addr == OFS_READ_PORT)
        else $error("clear pulse without data read");
    a_status_clear: assert property (status_read && !busy && !$past(busy) |=> !almost_full_flag)
        else $error("flag kept after status read");
    a_pop_clear: assert property (sample_ready_clear && !busy && !$past(busy) |=> !almost_full_flag)
        else $error("flag kept after data read");
    a_flag_cause: assert property ($rose(almost_full_flag) |-> $past(busy) || $past(busy, 2))
        else $error("flag rose without push");
    a_flag_sticky: assert property (almost_full_flag && !status_read && !sample_ready_clear
        && !reg_wr |=> almost_full_flag) else $error("flag dropped by itself");
    a_rdata_hold: assert property (!reg_rd && !$past(reg_rd) |=> $stable(reg_rdata))
        else $error("read data changed without read");
endmodule : tsf_sample_fifo_monitor
`default_nettype wire

//--- tb/tsf_host_model.sv
`default_nettype none
module tsf_host_model (
    input wire logic ref_clk,
    input wire logic [7:0] reg_rdata,
    output logic burst_start,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    output logic status_read
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {burst_start, reg_addr, reg_wr, reg_wdata, reg_rd, status_read} = '0;
    end
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'h1;
        @(negedge ref_clk);
        reg_rd = 1'h0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'h1;
        @(negedge ref_clk);
        reg_wr = 1'h0;
        reg_wdata = ~d;
    endtask : wr
    task automatic stat();
        @(negedge ref_clk);
        status_read = 1'h1;
        @(negedge ref_clk);
        status_read = 1'h0;
    endtask : stat
    task automatic word(output logic [15:0] w);
        @(negedge ref_clk);
        burst_start = 1'h1;
        @(negedge ref_clk);
        burst_start = 1'h0;
        rd(8'h08, w[15:8]);
        rd(8'h08, w[7:0]);
    endtask : word
    task automatic avail_by_count(output logic [7:0] n);
        logic [7:0] lost;
        logic [7:0] cnt;
        rd(8'h06, lost);
        rd(8'h07, cnt);
        n = (lost == 8'h00) ? cnt : 8'h20;
    endtask : avail_by_count
    task automatic avail_by_index(output logic [7:0] n);
        logic [7:0] lost;
        logic [7:0] wi;
        logic [7:0] ri;
        rd(8'h06, lost);
        rd(8'h04, wi);
        rd(8'h05, ri);
        n = (lost == 8'h00) ? ((wi - ri) & 8'h1F) : 8'h20;
    endtask : avail_by_index
endmodule : tsf_host_model
`default_nettype wire

//--- tb/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import tsf_pkg::*;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic sample_valid = 1'h0;
    logic [15:0] sample_data = 16'h0000;
    logic af_irq_enable = 1'h0;
    logic [1:0] event_pin_function = 2'h0;
    logic burst_start, reg_wr, reg_rd, status_read, addr_hold;
    logic almost_full_flag, sample_ready_clear, event_pin_irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, b;
    logic [15:0] w;
    logic [7:0] ra[8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0A, 8'h0B, 8'h03};
    int n_mismatch = 0;
    int comparisons = 0;
    tsf_sample_fifo i_dut (
        .ref_clk, .rst, .sample_valid, .sample_data, .burst_start, .reg_addr, .reg_wr,
        .reg_wdata, .reg_rd, .reg_rdata, .addr_hold, .status_read, .af_irq_enable,
        .event_pin_function, .almost_full_flag, .sample_ready_clear, .event_pin_irq
    );
    tsf_host_model i_host (
        .ref_clk, .reg_rdata, .burst_start, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .status_read
    );
    function automatic logic [15:0] samp(input int i);
        return 16'hC35A ^ (16'(i) * 16'h0101);
    endfunction : samp
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic reg_is(input logic [7:0] a, input logic [7:0] e);
        i_host.rd(a, b);
        chk(b, e);
    endtask : reg_is
    task automatic word_is(input int i);
        i_host.word(w);
        chk(w[15:8], 8'(samp(i) >> 8));
        chk(w[7:0], 8'(samp(i)));
    endtask : word_is
    task automatic flag_is(input logic e);
        repeat (2) @(negedge ref_clk);
        chk({6'h00, event_pin_irq, almost_full_flag}, {6'h00, e, e});
    endtask : flag_is
    task automatic push(input int i);
        @(negedge ref_clk);
        sample_valid = 1'h1;
        sample_data = samp(i);
        @(negedge ref_clk);
        sample_valid = 1'h0;
    endtask : push
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'h0;
        foreach (ra[k]) begin
            reg_is(ra[k], 8'h00);
        end
        af_irq_enable = 1'h1;
        event_pin_function = FUNC_AF_IRQ;
        i_host.wr(OFS_THRESH_CFG, 8'h02);
        reg_is(OFS_THRESH_CFG, 8'h02);
        for (int i = 0; i < 3; i++) begin
            push(i);
        end
        reg_is(OFS_WRITE_INDEX, 8'h03);
        word_is(0);
        reg_is(OFS_READ_INDEX, 8'h01);
        reg_is(OFS_AVAIL_COUNT, 8'h02);
        i_host.avail_by_index(b);
        chk(b, 8'h02);
        i_host.avail_by_count(b);
        chk(b, 8'h02);
        i_host.wr(OFS_READ_INDEX, 8'h00);
        word_is(0);
        i_host.wr(OFS_AVAIL_COUNT, 8'h09);
        reg_is(OFS_AVAIL_COUNT, 8'h01);
        i_host.wr(OFS_READ_PORT, 8'hFF);
        reg_is(OFS_READ_INDEX, 8'h01);
        i_host.wr(OFS_BEHAV_CFG, 8'h10);
        for (int k = 0; k < 4; k++) begin
            reg_is(ra[k], 8'h00);
        end
        reg_is(OFS_BEHAV_CFG, 8'h00);
        for (int i = 0; i < 64; i++) begin
            push(i);
        end
        reg_is(OFS_AVAIL_COUNT, 8'h20);
        reg_is(OFS_LOST_COUNT, 8'h1F);
        reg_is(OFS_WRITE_INDEX, 8'h00);
        i_host.avail_by_count(b);
        chk(b, 8'h20);
        i_host.avail_by_index(b);
        chk(b, 8'h20);
        flag_is(1'h1);
        event_pin_function = 2'h2;
        @(negedge ref_clk);
        chk({6'h00, event_pin_irq, almost_full_flag}, 8'h01);
        event_pin_function = FUNC_AF_IRQ;
        af_irq_enable = 1'h0;
        @(negedge ref_clk);
        chk({6'h00, event_pin_irq, almost_full_flag}, 8'h01);
        af_irq_enable = 1'h1;
        i_host.stat();
        flag_is(1'h0);
        push(64);
        flag_is(1'h1);
        reg_is(OFS_LOST_COUNT, 8'h1F);
        word_is(0);
        reg_is(OFS_LOST_COUNT, 8'h00);
        flag_is(1'h1);
        i_host.wr(OFS_BEHAV_CFG, 8'h0E);
        word_is(1);
        flag_is(1'h0);
        for (int i = 100; i < 103; i++) begin
            push(i);
        end
        flag_is(1'h0);
        reg_is(OFS_WRITE_INDEX, 8'h03);
        reg_is(OFS_READ_INDEX, 8'h03);
        reg_is(OFS_LOST_COUNT, 8'h01);
        reg_is(OFS_AVAIL_COUNT, 8'h20);
        word_is(3);
        i_host.wr(OFS_READ_INDEX, 8'h1F);
        word_is(31);
        reg_is(OFS_READ_INDEX, 8'h00);
        word_is(100);
        finish_test();
    end
endmodule : testbench
bind tsf_sample_fifo tsf_sample_fifo_monitor i_mon (
    .ref_clk, .rst, .sample_valid, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .addr_hold, .status_read,
    .af_irq_enable, .event_pin_function, .almost_full_flag, .sample_ready_clear, .event_pin_irq
);
`default_nettype wire
